// ---- shared/sarcr_pkg.sv ----
// Shared constants and types for the converter control and serial readout block.
package sarcr_pkg;

  localparam int RESULT_WIDTH  = 18;
  localparam int ADDR_WIDTH    = 12;
  localparam int DATA_WIDTH    = 32;
  localparam int COUNT_WIDTH   = 8;

  localparam int CLK_PERIOD_NS = 100;
  localparam int CONV_TIME_NS  = 412;
  localparam int CONV_RAW      = CONV_TIME_NS / CLK_PERIOD_NS;
  localparam int CONV_CYCLES   = (CONV_RAW < 1) ? 1 : CONV_RAW;
  localparam int POR_TIME_US   = 20;
  localparam int POR_CYCLES    = (POR_TIME_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  localparam logic [ADDR_WIDTH-1:0] CTRL_OFFSET   = 12'h000;
  localparam logic [ADDR_WIDTH-1:0] STATUS_OFFSET = 12'h004;
  localparam logic [ADDR_WIDTH-1:0] RESULT_OFFSET = 12'h008;

  localparam int CTRL_CHAIN_BIT   = 0;
  localparam int CTRL_REFSEL_BIT  = 1;
  localparam logic [1:0] CTRL_RESET = 2'h2;

  localparam int STATUS_BUSY_BIT  = 0;
  localparam int STATUS_READY_BIT = 1;
  localparam int STATUS_DOWN_BIT  = 2;

  localparam int GAIN_NUM    = 4;
  localparam int GAIN_DEN    = 5;
  localparam int GAIN_OFFSET = (1 << RESULT_WIDTH) / 10;

  typedef enum logic [1:0] {
    ST_POR_INIT     = 2'b00,
    ST_POWERED_DOWN = 2'b01,
    ST_CONVERTING   = 2'b10
  } sarcr_state_type;

  typedef struct packed {
    logic                  psel;
    logic                  penable;
    logic                  pwrite;
    logic [ADDR_WIDTH-1:0] paddr;
    logic [DATA_WIDTH-1:0] pwdata;
  } sarcr_apb_req_type;

  typedef struct packed {
    logic [DATA_WIDTH-1:0] prdata;
    logic                  pready;
    logic                  pslverr;
  } sarcr_apb_rsp_type;

endpackage

// ---- rtl/sarcr_core.sv ----
// Conversion control, power-down and serial readout with an APB register slave.
`timescale 1ns/1ps
// Overview of operation
// - Supply loss resets; reinitialise after supply returns.
// - Start rising edge powers up, begins conversion.
// - Start requests ignored while converting.
// - Busy high exactly for the conversion.
// - After conversion, power down and acquire.
// - Conversion finishes within 412 ns.
// - Last result stays readable while powered down.
// - Result shifts out with the external clock.
// - Output changes on rising serial clock edge.
// - Top bit held until first rising edge.
// - Normal mode: read enable low drives output.
// - Top bit present at falling edge of busy.
// - Shared output: one read enable low.
// - Chain mode: output always on, serial input.
// - Upstream top bit appears after 18 clocks.
// - Upstream top bit captured on first edge.
// - Gain compression maps result into 10%..90%.

module sarcr_core #(
  parameter int POR_COUNT = sarcr_pkg::POR_CYCLES
) (
  input  wire logic                                   clk,
  input  wire logic                                   reset,
  input  wire sarcr_pkg::sarcr_apb_req_type           apbReq,
  output sarcr_pkg::sarcr_apb_rsp_type                apbRsp,
  input  wire logic                                   conversionStart,
  input  wire logic                                   sck,
  input  wire logic                                   readEnableOrChainInput,
  input  wire logic                                   supplyAboveMin,
  input  wire logic [sarcr_pkg::RESULT_WIDTH-1:0]     analogCode,
  output logic                                        busy,
  output logic                                        sdo,
  output logic                                        sdoOe
);

  localparam int RW = sarcr_pkg::RESULT_WIDTH;
  localparam int CW = sarcr_pkg::COUNT_WIDTH;
  localparam int PW = RW + 3;

  //////////////////////////////////////////////////////////////////////////////
  // Input synchronisers and edge detection.

  logic [3:0]    pinSync1;
  logic [3:0]    pinSync2;
  logic [3:0]    pinDly;
  logic [RW-1:0] codeSync1;
  logic [RW-1:0] codeSync2;
  logic          cnvRise;
  logic          sckRise;
  logic          rdlLevel;
  logic          supplyOk;

  always_ff @(posedge clk) begin
    if (reset) begin
      pinSync1  <= 4'h0;
      pinSync2  <= 4'h0;
      pinDly    <= 4'h0;
      codeSync1 <= '0;
      codeSync2 <= '0;
    end else begin
      pinSync1  <= {supplyAboveMin, readEnableOrChainInput, sck, conversionStart};
      pinSync2  <= pinSync1;
      pinDly    <= pinSync2;
      codeSync1 <= analogCode;
      codeSync2 <= codeSync1;
    end
  end

  always_comb begin
    cnvRise  = pinSync2[0] & ~pinDly[0];
    sckRise  = pinSync2[1] & ~pinDly[1];
    rdlLevel = pinSync2[2];
    supplyOk = pinSync2[3];
  end

  //////////////////////////////////////////////////////////////////////////////
  // Control register state.

  logic chainMode;
  logic referenceGainSelect;
  logic next_chainMode;
  logic next_referenceGainSelect;

  //////////////////////////////////////////////////////////////////////////////
  // Conversion state machine.

  sarcr_pkg::sarcr_state_type state;
  sarcr_pkg::sarcr_state_type next_state;
  logic [CW-1:0]              count;
  logic [CW-1:0]              next_count;
  logic [RW-1:0]              heldSample;
  logic [RW-1:0]              next_heldSample;
  logic                       next_busy;
  logic                       loadResult;

  always_comb begin
    next_state      = state;
    next_count      = count;
    next_heldSample = heldSample;
    loadResult      = 1'b0;
    case (state)
      sarcr_pkg::ST_POR_INIT: begin
        if (count == '0) begin
          next_state = sarcr_pkg::ST_POWERED_DOWN;
        end else begin
          next_count = count - CW'(1);
        end
      end
      sarcr_pkg::ST_POWERED_DOWN: begin
        if (cnvRise) begin
          next_state      = sarcr_pkg::ST_CONVERTING;
          next_count      = CW'(sarcr_pkg::CONV_CYCLES - 1);
          next_heldSample = codeSync2;
        end
      end
      sarcr_pkg::ST_CONVERTING: begin
        if (count == '0) begin
          next_state = sarcr_pkg::ST_POWERED_DOWN;
          loadResult = 1'b1;
        end else begin
          next_count = count - CW'(1);
        end
      end
      default: begin
        next_state = sarcr_pkg::ST_POR_INIT;
        next_count = CW'(POR_COUNT - 1);
      end
    endcase
    if (!supplyOk) begin
      next_state = sarcr_pkg::ST_POR_INIT;
      next_count = CW'(POR_COUNT - 1);
      loadResult = 1'b0;
    end
    next_busy = (next_state == sarcr_pkg::ST_CONVERTING);
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      state      <= sarcr_pkg::ST_POR_INIT;
      count      <= CW'(POR_COUNT - 1);
      heldSample <= '0;
      busy       <= 1'b0;
    end else begin
      state      <= next_state;
      count      <= next_count;
      heldSample <= next_heldSample;
      busy       <= next_busy;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Result scaling and serial output.

  logic [PW-1:0] product;
  logic [PW-1:0] scaled;
  logic [RW-1:0] resultValue;
  logic [RW-1:0] resultReg;
  logic [RW-1:0] next_resultReg;
  logic [RW-1:0] shiftReg;
  logic [RW-1:0] next_shiftReg;
  logic          shiftIn;
  logic          next_sdo;
  logic          next_sdoOe;

  always_comb begin
    product = PW'(heldSample) * PW'(sarcr_pkg::GAIN_NUM);
    scaled  = product / PW'(sarcr_pkg::GAIN_DEN) + PW'(sarcr_pkg::GAIN_OFFSET);
    if (!referenceGainSelect) begin
      resultValue = scaled[RW-1:0];
    end else begin
      resultValue = heldSample;
    end
    shiftIn        = chainMode ? rdlLevel : 1'b0;
    next_resultReg = resultReg;
    next_shiftReg  = shiftReg;
    if (loadResult) begin
      next_resultReg = resultValue;
      next_shiftReg  = resultValue;
    end else if (sckRise) begin
      next_shiftReg = {shiftReg[RW-2:0], shiftIn};
    end
    next_sdo   = next_shiftReg[RW-1];
    next_sdoOe = chainMode | ~rdlLevel;
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      resultReg <= '0;
      shiftReg  <= '0;
      sdo       <= 1'b0;
      sdoOe     <= 1'b0;
    end else begin
      resultReg <= next_resultReg;
      shiftReg  <= next_shiftReg;
      sdo       <= next_sdo;
      sdoOe     <= next_sdoOe;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // APB register slave.

  sarcr_pkg::sarcr_apb_rsp_type next_apbRsp;
  logic                         accessPhase;
  logic                         writeDone;
  logic [sarcr_pkg::DATA_WIDTH-1:0] readMux;
  logic                         addrHit;

  always_comb begin
    accessPhase = apbReq.psel & apbReq.penable;
    writeDone   = accessPhase & apbRsp.pready & apbReq.pwrite;
    readMux     = '0;
    addrHit     = 1'b1;
    case (apbReq.paddr)
      sarcr_pkg::CTRL_OFFSET: begin
        readMux[sarcr_pkg::CTRL_CHAIN_BIT]  = chainMode;
        readMux[sarcr_pkg::CTRL_REFSEL_BIT] = referenceGainSelect;
      end
      sarcr_pkg::STATUS_OFFSET: begin
        readMux[sarcr_pkg::STATUS_BUSY_BIT]  = busy;
        readMux[sarcr_pkg::STATUS_READY_BIT] = (state != sarcr_pkg::ST_POR_INIT);
        readMux[sarcr_pkg::STATUS_DOWN_BIT]  = (state == sarcr_pkg::ST_POWERED_DOWN);
      end
      sarcr_pkg::RESULT_OFFSET: begin
        readMux[RW-1:0] = resultReg;
      end
      default: begin
        addrHit = 1'b0;
      end
    endcase
    next_apbRsp         = '0;
    next_apbRsp.pready  = accessPhase & ~apbRsp.pready;
    next_apbRsp.pslverr = accessPhase & ~apbRsp.pready & ~addrHit;
    if (accessPhase && !apbRsp.pready && !apbReq.pwrite) begin
      next_apbRsp.prdata = readMux;
    end
    next_chainMode           = chainMode;
    next_referenceGainSelect = referenceGainSelect;
    if (writeDone && apbReq.paddr == sarcr_pkg::CTRL_OFFSET) begin
      next_chainMode           = apbReq.pwdata[sarcr_pkg::CTRL_CHAIN_BIT];
      next_referenceGainSelect = apbReq.pwdata[sarcr_pkg::CTRL_REFSEL_BIT];
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      apbRsp              <= '0;
      chainMode           <= sarcr_pkg::CTRL_RESET[sarcr_pkg::CTRL_CHAIN_BIT];
      referenceGainSelect <= sarcr_pkg::CTRL_RESET[sarcr_pkg::CTRL_REFSEL_BIT];
    end else begin
      apbRsp              <= next_apbRsp;
      chainMode           <= next_chainMode;
      referenceGainSelect <= next_referenceGainSelect;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Assertions and cover properties.

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (reset);

  a_busy_length: assert property ($rose(busy) |-> busy [*4] ##1 !busy)
    else $error("Busy did not last exactly the conversion time.");

  a_start_begins: assert property (
    (state == sarcr_pkg::ST_POWERED_DOWN && cnvRise && supplyOk) |=> busy)
    else $error("Start edge did not begin a conversion.");

  a_start_ignored: assert property (
    (state == sarcr_pkg::ST_CONVERTING && count != '0 && supplyOk)
      |=> count == $past(count) - CW'(1))
    else $error("Conversion progress disturbed by a start request.");

  a_power_down: assert property (
    $fell(busy) && $past(supplyOk) |-> state == sarcr_pkg::ST_POWERED_DOWN)
    else $error("Block not powered down after conversion.");

  a_msb_at_fall: assert property (
    $fell(busy) && $past(supplyOk) |-> sdo == resultReg[RW-1] && shiftReg == resultReg)
    else $error("Top result bit missing at falling edge of busy.");

  a_normal_hiz: assert property (!chainMode && rdlLevel |=> !sdoOe)
    else $error("Serial output driven while read enable high.");

  a_chain_drive: assert property (chainMode |=> sdoOe)
    else $error("Serial output not enabled in chain mode.");

  a_shift_step: assert property (sckRise && !loadResult
    |=> shiftReg == {$past(shiftReg[RW-2:0]), $past(shiftIn)} && sdo == shiftReg[RW-1])
    else $error("Shift register did not step on serial clock edge.");

  a_msb_hold: assert property (!sckRise && !loadResult |=> $stable(shiftReg))
    else $error("Output data changed without a serial clock edge.");

  a_supply_loss: assert property (!supplyOk |=> state == sarcr_pkg::ST_POR_INIT ##1 !busy)
    else $error("Supply loss did not reinitialise the block.");

  a_gain_range: assert property (loadResult && !referenceGainSelect
    |=> resultReg >= RW'(sarcr_pkg::GAIN_OFFSET))
    else $error("Compressed result below the lower bound.");

  c_conversion: cover property ($rose(busy) ##[1:8] $fell(busy));
  c_chain_shift: cover property (chainMode && sckRise && rdlLevel);
  c_por_exit: cover property (state == sarcr_pkg::ST_POR_INIT
    ##1 state == sarcr_pkg::ST_POWERED_DOWN);

endmodule // sarcr_core

// ---- dv/sarcr_host_model.sv ----
// Host model that drives the start pin, the serial clock and the chain input.
`timescale 1ns/1ps
module sarcr_host_model (
  input  wire logic clk,
  input  wire logic sdo,
  input  wire logic busy,
  output logic      conversionStart,
  output logic      sck,
  output logic      readEnableOrChainInput
);
  initial begin
    conversionStart = 1'b0;
    sck = 1'b0;
    readEnableOrChainInput = 1'b0;
  end
  // Starts one conversion, optionally with a second edge right after the first.
  task automatic convert(input bit glitch);
    @(posedge clk) conversionStart <= 1'b1;
    if (glitch) begin
      @(posedge clk) conversionStart <= 1'b0;
      @(posedge clk) conversionStart <= 1'b1;
    end
    for (int k = 0; k < 10 && busy !== 1'b1; k++) @(posedge clk);
    for (int k = 0; k < 10 && busy !== 1'b0; k++) @(posedge clk);
    conversionStart <= 1'b0;
    repeat (2) @(posedge clk);
  endtask
  // Sets the read enable level.
  task automatic line(input logic v);
    @(posedge clk) readEnableOrChainInput <= v;
    repeat (5) @(posedge clk);
  endtask
  // Clocks n bits out, sampling each one before the next rising edge.
  task automatic shift(input int n, input logic [17:0] up, input bit chain,
                       output logic [35:0] got);
    got = '0;
    if (chain) readEnableOrChainInput <= up[17];
    for (int i = 0; i < n; i++) begin
      repeat (4) @(posedge clk);
      got[n-1-i] = sdo;
      sck <= 1'b1;
      repeat (4) @(posedge clk);
      sck <= 1'b0;
      if (chain && i < 17) readEnableOrChainInput <= up[16-i];
    end
  endtask
endmodule // sarcr_host_model

// ---- dv/sarcr_core_tb.sv ----
// Self-checking testbench for the converter control and serial readout block.
`timescale 1ns/1ps
module sarcr_core_tb;
  typedef struct packed {
    logic [17:0] code;
    logic        refSel;
    logic [17:0] exp;
  } sarcr_row_type;
  logic clk = 1'b0;
  logic reset;
  logic supplyAboveMin;
  logic [17:0] analogCode;
  sarcr_pkg::sarcr_apb_req_type apbReq;
  sarcr_pkg::sarcr_apb_rsp_type apbRsp;
  logic conversionStart, sck, readEnableOrChainInput, busy, sdo, sdoOe, sdoLine, fallSdo;
  logic [31:0] rd;
  logic        er;
  logic [35:0] got;
  int err_count = 0;
  int checked = 0;
  int cycles = 0;
  int busyLen = 0;
  int lastWidth = 0;
  int busyRises = 0;
  int r0;
  bit prevBusy = 0;
  sarcr_row_type rows [5] = '{'{18'h3ffff, 1'b1, 18'h3ffff}, '{18'h00001, 1'b1, 18'h00001},
    '{18'h2a5a5, 1'b1, 18'h2a5a5}, '{18'h3ffff, 1'b0, 18'h39998}, '{18'h00000, 1'b0, 18'h06666}};
  assign sdoLine = sdoOe ? sdo : 1'b1;
  always #50 clk = ~clk;
  sarcr_core #(.POR_COUNT(10)) uut (.clk(clk), .reset(reset), .apbReq(apbReq),
    .apbRsp(apbRsp), .conversionStart(conversionStart), .sck(sck),
    .readEnableOrChainInput(readEnableOrChainInput), .supplyAboveMin(supplyAboveMin),
    .analogCode(analogCode), .busy(busy), .sdo(sdo), .sdoOe(sdoOe));
  sarcr_host_model host (.clk(clk), .sdo(sdoLine), .busy(busy),
    .conversionStart(conversionStart), .sck(sck),
    .readEnableOrChainInput(readEnableOrChainInput));
  ////////////////////////////////////////////////////////////////////////////////
  always @(posedge clk) begin
    cycles++;
    if (cycles == 20000) begin
      err_count++;
      tally_and_finish();
    end
    if (busy === 1'b1) begin
      busyLen++;
      if (!prevBusy) busyRises++;
    end else if (prevBusy) begin
      lastWidth = busyLen;
      busyLen = 0;
      fallSdo = sdo;
    end
    prevBusy = (busy === 1'b1);
  end
  task automatic check(input logic [35:0] seen, input logic [35:0] exp);
    checked++;
    if (seen !== exp) begin
      err_count++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic apb(input logic wr, input logic [11:0] addr, input logic [31:0] wd);
    @(posedge clk);
    apbReq <= '{psel: 1'b1, penable: 1'b0, pwrite: wr, paddr: addr, pwdata: wd};
    @(posedge clk) apbReq.penable <= 1'b1;
    do begin
      @(posedge clk);
    end while (apbRsp.pready !== 1'b1);
    rd = apbRsp.prdata;
    er = apbRsp.pslverr;
    apbReq <= '0;
  endtask
  task automatic tally_and_finish();
    $display("checks=%0d errors=%0d", checked, err_count);
    if (err_count == 0 && checked > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    reset <= 1'b1;
    supplyAboveMin <= 1'b1;
    analogCode <= '0;
    apbReq <= '0;
    repeat (20) @(posedge clk);
    reset <= 1'b0;
    repeat (20) @(posedge clk);
    apb(1'b0, sarcr_pkg::STATUS_OFFSET, 32'h0);
    check({35'h0, rd[sarcr_pkg::STATUS_READY_BIT]}, 36'h1);
    foreach (rows[i]) begin
      apb(1'b1, sarcr_pkg::CTRL_OFFSET, {30'h0, rows[i].refSel, 1'b0});
      analogCode <= rows[i].code;
      host.convert(1'b0);
      check(36'(lastWidth), 36'h4);
      check({35'h0, fallSdo}, {35'h0, rows[i].exp[17]});
      host.shift(18, 18'h0, 1'b0, got);
      check(got, {18'h0, rows[i].exp});
      apb(1'b0, sarcr_pkg::RESULT_OFFSET, 32'h0);
      check({4'h0, rd}, {18'h0, rows[i].exp});
      apb(1'b0, sarcr_pkg::STATUS_OFFSET, 32'h0);
      check({35'h0, rd[sarcr_pkg::STATUS_DOWN_BIT]}, 36'h1);
    end
    apb(1'b1, sarcr_pkg::CTRL_OFFSET, 32'h2);
    analogCode <= 18'h20000;
    r0 = busyRises;
    host.convert(1'b1);
    repeat (10) @(posedge clk);
    check(36'(busyRises - r0), 36'h1);
    check(36'(lastWidth), 36'h4);
    host.line(1'b1);
    check({35'h0, sdoOe}, 36'h0);
    host.line(1'b0);
    check({34'h0, sdoOe, sdo}, 36'h3);
    apb(1'b1, sarcr_pkg::CTRL_OFFSET, 32'h3);
    analogCode <= 18'h15a3c;
    host.convert(1'b0);
    host.line(1'b1);
    check({35'h0, sdoOe}, 36'h1);
    host.shift(36, 18'h1b2c3, 1'b1, got);
    check(got, {18'h15a3c, 18'h1b2c3});
    apb(1'b0, 12'h0f0, 32'h0);
    check({34'h0, er, 1'b0}, 36'h2);
    supplyAboveMin <= 1'b0;
    repeat (5) @(posedge clk);
    supplyAboveMin <= 1'b1;
    apb(1'b0, sarcr_pkg::STATUS_OFFSET, 32'h0);
    check({35'h0, rd[sarcr_pkg::STATUS_READY_BIT]}, 36'h0);
    repeat (30) @(posedge clk);
    apb(1'b0, sarcr_pkg::STATUS_OFFSET, 32'h0);
    check({35'h0, rd[sarcr_pkg::STATUS_READY_BIT]}, 36'h1);
    reset <= 1'b1;
    repeat (3) @(posedge clk);
    check({busy, sdoOe, apbRsp}, 36'h0);
    reset <= 1'b0;
    tally_and_finish();
  end
endmodule // sarcr_core_tb
